// ===== logic/drive_alarm_status_reporter.sv
module drive_alarm_status_reporter #(
  parameter logic [15:0] FAULT_MASK = drive_report_pkg::FAULT_MASK_DEFAULT,
  parameter bit          SERVO_TYPE = 1'b1
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  output logic      [7:0]  tx_byte_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  input  wire logic [15:0] alarm_set_i,
  input  wire logic        alarm_clear_i,
  input  wire logic        motor_enable_req_i,
  input  wire logic        tuner_sampling_i,
  input  wire logic        in_position_i,
  input  wire logic        moving_i,
  input  wire logic        jogging_i,
  input  wire logic        stopping_i,
  input  wire logic        wait_on_input_op_i,
  input  wire logic        saving_i,
  input  wire logic        homing_op_i,
  input  wire logic        timed_delay_op_i,
  input  wire logic        wizard_running_i,
  input  wire logic        encoder_check_i,
  input  wire logic        program_running_i,
  input  wire logic        initializing_i,
  output logic      [15:0] alarm_word_o,
  output logic      [15:0] drive_condition_word_o,
  output logic             motor_disable_o,
  output logic             fault_branch_op_o
);

  localparam int W = drive_report_pkg::WORD_W;

  //////////////////////////////////////////////////////////////////////////////

  logic [W-1:0] next_alarm;
  logic [W-1:0] next_status;
  logic         next_fault;

  // Alarm-reset and a new event in the same cycle: the event survives.
  always_comb
  begin
    next_alarm = (alarm_clear_i ? drive_report_pkg::WORD_RESET
                                : alarm_word_o) | alarm_set_i;
    next_fault = |(next_alarm & FAULT_MASK);
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      alarm_word_o      <= drive_report_pkg::WORD_RESET;
      motor_disable_o   <= 1'b0;
      fault_branch_op_o <= 1'b0;
    end
    else
    begin
      alarm_word_o      <= next_alarm;
      motor_disable_o   <= next_fault;
      fault_branch_op_o <= next_fault;
    end
  end

  always_comb
  begin
    next_status = drive_report_pkg::WORD_RESET;
    next_status[drive_report_pkg::ST_ENABLED] =
      motor_enable_req_i & ~next_fault;
    next_status[drive_report_pkg::ST_SAMPLING]   = tuner_sampling_i;
    next_status[drive_report_pkg::ST_FAULT]      = next_fault;
    next_status[drive_report_pkg::ST_IN_POS]     =
      SERVO_TYPE & in_position_i;
    next_status[drive_report_pkg::ST_MOVING]     = moving_i;
    next_status[drive_report_pkg::ST_JOGGING]    = jogging_i;
    next_status[drive_report_pkg::ST_STOPPING]   = stopping_i;
    next_status[drive_report_pkg::ST_WAIT_INPUT] = wait_on_input_op_i;
    next_status[drive_report_pkg::ST_SAVING]     = saving_i;
    next_status[drive_report_pkg::ST_ALARM]      = |next_alarm;
    next_status[drive_report_pkg::ST_HOMING]     = homing_op_i;
    next_status[drive_report_pkg::ST_TIMED_WAIT] = timed_delay_op_i;
    next_status[drive_report_pkg::ST_WIZARD]     = wizard_running_i;
    next_status[drive_report_pkg::ST_ENC_CHECK]  = encoder_check_i;
    next_status[drive_report_pkg::ST_PROGRAM]    = program_running_i;
    next_status[drive_report_pkg::ST_INIT]       = initializing_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      drive_condition_word_o <= drive_report_pkg::WORD_RESET;
    else
      drive_condition_word_o <= next_status;
  end

  //////////////////////////////////////////////////////////////////////////////

  drive_report_pkg::reply_state_t state;
  drive_report_pkg::reply_state_t next_state;

  logic [7:0]   name_buf [drive_report_pkg::NAME_MAX];
  logic [1:0]   name_len;
  logic [1:0]   reply_len;
  logic         overflow;
  logic         rx_take;
  logic         end_of_cmd;
  logic         hit_hex_alarm;
  logic         hit_hex_status;
  logic         hit_dec_alarm;
  logic         hit_dec_status;
  logic         cmd_hit;
  logic         use_dec;
  logic [W-1:0] value_snap;
  logic [W-1:0] chosen;

  // Replies are not interleaved with new commands; the host is held off.
  assign rx_ready_o = (state == drive_report_pkg::S_IDLE);
  assign rx_take    = rx_valid_i & rx_ready_o;
  assign end_of_cmd = rx_take & (rx_byte_i == drive_report_pkg::ASCII_CR)
                      & ~overflow;

  always_comb
  begin
    hit_hex_alarm  = end_of_cmd && name_len == 2'd2
      && name_buf[0] == drive_report_pkg::CH_UPPER_A
      && name_buf[1] == drive_report_pkg::CH_UPPER_L;
    hit_hex_status = end_of_cmd && name_len == 2'd2
      && name_buf[0] == drive_report_pkg::CH_UPPER_S
      && name_buf[1] == drive_report_pkg::CH_UPPER_C;
    hit_dec_alarm  = end_of_cmd && name_len == 2'd3
      && name_buf[0] == drive_report_pkg::CH_UPPER_R
      && name_buf[1] == drive_report_pkg::CH_UPPER_L
      && name_buf[2] == drive_report_pkg::CH_LOWER_F;
    hit_dec_status = end_of_cmd && name_len == 2'd3
      && name_buf[0] == drive_report_pkg::CH_UPPER_R
      && name_buf[1] == drive_report_pkg::CH_UPPER_L
      && name_buf[2] == drive_report_pkg::CH_LOWER_S;
    cmd_hit = hit_hex_alarm | hit_hex_status | hit_dec_alarm | hit_dec_status;
    chosen  = (hit_hex_alarm | hit_dec_alarm) ? alarm_word_o
                                              : drive_condition_word_o;
  end

  // Unknown or over-long commands are dropped silently at the line end.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      name_len <= 2'd0;
      overflow <= 1'b0;
      for (int i = 0; i < drive_report_pkg::NAME_MAX; i++)
        name_buf[i] <= 8'h00;
    end
    else if (rx_take)
    begin
      if (rx_byte_i == drive_report_pkg::ASCII_CR)
      begin
        name_len <= 2'd0;
        overflow <= 1'b0;
      end
      else if (name_len < 2'(drive_report_pkg::NAME_MAX))
      begin
        name_buf[name_len] <= rx_byte_i;
        name_len           <= name_len + 2'd1;
      end
      else
        overflow <= 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      reply_len  <= 2'd0;
      use_dec    <= 1'b0;
      value_snap <= drive_report_pkg::WORD_RESET;
    end
    else if (cmd_hit)
    begin
      reply_len  <= name_len;
      use_dec    <= hit_dec_alarm | hit_dec_status;
      value_snap <= chosen;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  logic [8*drive_report_pkg::HEX_DIGITS-1:0] hex_chars;
  logic [8*drive_report_pkg::DEC_DIGITS-1:0] dec_chars;
  logic [8*drive_report_pkg::DEC_DIGITS-1:0] digit_chars;
  logic [2:0]                                hex_count;
  logic [2:0]                                dec_count;
  logic [2:0]                                digit_count;
  logic                                      dec_done;

  hex_text #(
    .W (W)
  ) u_hex (
    .value_i (value_snap),
    .chars_o (hex_chars),
    .count_o (hex_count)
  );

  decimal_text #(
    .W (W),
    .D (drive_report_pkg::DEC_DIGITS)
  ) u_dec (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (hit_dec_alarm | hit_dec_status),
    .value_i   (chosen),
    .done_o    (dec_done),
    .chars_o   (dec_chars),
    .count_o   (dec_count)
  );

  //////////////////////////////////////////////////////////////////////////////

  logic [2:0] idx;
  logic [2:0] next_idx;
  logic [7:0] next_tx;

  always_comb
  begin
    next_state = state;
    next_idx   = idx;
    case (state)
      drive_report_pkg::S_IDLE:
        if (cmd_hit)
          next_state = drive_report_pkg::S_CONVERT;
      drive_report_pkg::S_CONVERT:
        if (!use_dec || dec_done)
        begin
          next_state = drive_report_pkg::S_NAME;
          next_idx   = 3'd0;
        end
      drive_report_pkg::S_NAME:
        if (tx_ready_i)
        begin
          if (idx == 3'(reply_len) - 3'd1)
            next_state = drive_report_pkg::S_EQUAL;
          else
            next_idx = idx + 3'd1;
        end
      drive_report_pkg::S_EQUAL:
        if (tx_ready_i)
        begin
          next_state = drive_report_pkg::S_DIGITS;
          next_idx   = digit_count - 3'd1;
        end
      drive_report_pkg::S_DIGITS:
        if (tx_ready_i)
        begin
          if (idx == 3'd0)
            next_state = drive_report_pkg::S_ENDLINE;
          else
            next_idx = idx - 3'd1;
        end
      drive_report_pkg::S_ENDLINE:
        if (tx_ready_i)
          next_state = drive_report_pkg::S_IDLE;
      default:
        next_state = drive_report_pkg::S_IDLE;
    endcase
  end

  always_comb
  begin
    case (next_state)
      drive_report_pkg::S_NAME:    next_tx = name_buf[next_idx[1:0]];
      drive_report_pkg::S_EQUAL:   next_tx = drive_report_pkg::ASCII_EQ;
      drive_report_pkg::S_DIGITS:  next_tx = digit_chars[8*next_idx +: 8];
      drive_report_pkg::S_ENDLINE: next_tx = drive_report_pkg::ASCII_CR;
      default:                     next_tx = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state     <= drive_report_pkg::S_IDLE;
      idx       <= 3'd0;
      tx_byte_o <= 8'h00;
    end
    else
    begin
      state     <= next_state;
      idx       <= next_idx;
      tx_byte_o <= next_tx;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      digit_chars <= '0;
      digit_count <= 3'h1;
    end
    else if (state == drive_report_pkg::S_CONVERT)
    begin
      digit_chars <= use_dec ? dec_chars : {8'h00, hex_chars};
      digit_count <= use_dec ? dec_count : hex_count;
    end
  end

  assign tx_valid_o = (state != drive_report_pkg::S_IDLE)
                      && (state != drive_report_pkg::S_CONVERT);

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_alarm_sticky_set: assert property (
    (alarm_set_i != 16'h0000) |=>
      ((alarm_word_o & $past(alarm_set_i)) == $past(alarm_set_i)))
    else $error("alarm event lost");

  a_alarm_hold_value: assert property (
    (!alarm_clear_i && alarm_set_i == 16'h0000) |=> $stable(alarm_word_o))
    else $error("alarm word changed without cause");

  a_cw_bit_weight: assert property (
    alarm_set_i[drive_report_pkg::ALM_CW_LIMIT] |=>
      ((alarm_word_o & 16'h0004) == 16'h0004))
    else $error("clockwise limit not at weight 0004");

  a_fault_disables: assert property (
    ((alarm_word_o & FAULT_MASK) != 16'h0000) |-> motor_disable_o)
    else $error("fault did not disable motor");

  a_enable_bit_off: assert property (
    drive_condition_word_o[drive_report_pkg::ST_ENABLED] |->
      !motor_disable_o && !drive_condition_word_o[drive_report_pkg::ST_FAULT])
    else $error("enabled bit set during fault");

  a_alarm_present_bit: assert property (
    drive_condition_word_o[drive_report_pkg::ST_ALARM] ==
      (alarm_word_o != 16'h0000))
    else $error("alarm present bit wrong");

  a_wait_input_bit: assert property (
    wait_on_input_op_i |=>
      drive_condition_word_o[drive_report_pkg::ST_WAIT_INPUT])
    else $error("wait on input bit missing");

  a_servo_in_pos: assert property (
    in_position_i |=>
      drive_condition_word_o[drive_report_pkg::ST_IN_POS] == SERVO_TYPE)
    else $error("in position bit wrong for drive type");

  a_query_accepted: assert property (
    cmd_hit |=> state == drive_report_pkg::S_CONVERT ##1
      state == drive_report_pkg::S_NAME || use_dec)
    else $error("query not accepted");

  a_dec_conversion: assert property (
    (hit_dec_alarm || hit_dec_status) |-> ##[16:18] dec_done)
    else $error("decimal conversion overdue");

  a_equal_sign_sent: assert property (
    state == drive_report_pkg::S_EQUAL |->
      tx_byte_o == drive_report_pkg::ASCII_EQ)
    else $error("equals sign missing");

  a_no_lead_zero: assert property (
    (state == drive_report_pkg::S_DIGITS && idx == digit_count - 3'd1
      && digit_count > 3'd1) |-> tx_byte_o != drive_report_pkg::ASCII_ZERO)
    else $error("leading zero sent");

  c_hex_alarm_query:  cover property (hit_hex_alarm ##[1:20] tx_valid_o);
  c_dec_status_query: cover property (hit_dec_status ##[17:40]
    state == drive_report_pkg::S_ENDLINE);
  c_set_meets_clear:  cover property (alarm_clear_i && alarm_set_i != 16'h0);

endmodule : drive_alarm_status_reporter

// ===== include/drive_report_pkg.sv
package drive_report_pkg;

  localparam int WORD_W     = 16;
  localparam int HEX_DIGITS = 4;
  localparam int DEC_DIGITS = 5;
  localparam int NAME_MAX   = 3;

  localparam logic [7:0] ASCII_CR      = 8'h0d;
  localparam logic [7:0] ASCII_EQ      = 8'h3d;
  localparam logic [7:0] ASCII_ZERO    = 8'h30;
  localparam logic [7:0] CH_UPPER_A    = 8'h41;
  localparam logic [7:0] CH_UPPER_C    = 8'h43;
  localparam logic [7:0] CH_UPPER_L    = 8'h4c;
  localparam logic [7:0] CH_UPPER_R    = 8'h52;
  localparam logic [7:0] CH_UPPER_S    = 8'h53;
  localparam logic [7:0] CH_LOWER_F    = 8'h66;
  localparam logic [7:0] CH_LOWER_S    = 8'h73;

  // Alarm word bit positions.
  localparam int ALM_POS_LIMIT  = 0;
  localparam int ALM_CCW_LIMIT  = 1;
  localparam int ALM_CW_LIMIT   = 2;
  localparam int ALM_OVER_TEMP  = 3;
  localparam int ALM_OVER_VOLT  = 5;
  localparam int ALM_UNDER_VOLT = 6;
  localparam int ALM_OVER_CUR   = 7;
  localparam int ALM_ENCODER    = 9;
  localparam int ALM_COMM       = 10;
  localparam int ALM_BAD_FLASH  = 11;
  localparam int ALM_BLANK_SEG  = 14;

  // Condition word bit positions.
  localparam int ST_ENABLED     = 0;
  localparam int ST_SAMPLING    = 1;
  localparam int ST_FAULT       = 2;
  localparam int ST_IN_POS      = 3;
  localparam int ST_MOVING      = 4;
  localparam int ST_JOGGING     = 5;
  localparam int ST_STOPPING    = 6;
  localparam int ST_WAIT_INPUT  = 7;
  localparam int ST_SAVING      = 8;
  localparam int ST_ALARM       = 9;
  localparam int ST_HOMING      = 10;
  localparam int ST_TIMED_WAIT  = 11;
  localparam int ST_WIZARD      = 12;
  localparam int ST_ENC_CHECK   = 13;
  localparam int ST_PROGRAM     = 14;
  localparam int ST_INIT        = 15;

  localparam logic [WORD_W-1:0] FAULT_MASK_DEFAULT = 16'h0aa8;
  localparam logic [WORD_W-1:0] WORD_RESET         = 16'h0000;

  typedef enum logic [5:0] {
    S_IDLE    = 6'b000001,
    S_CONVERT = 6'b000010,
    S_NAME    = 6'b000100,
    S_EQUAL   = 6'b001000,
    S_DIGITS  = 6'b010000,
    S_ENDLINE = 6'b100000
  } reply_state_t;

endpackage : drive_report_pkg

// ===== logic/hex_text.sv
module hex_text #(
  parameter int W = drive_report_pkg::WORD_W
) (
  input  wire logic [W-1:0]       value_i,
  output logic      [2*W-1:0]     chars_o,
  output logic      [2:0]         count_o
);

  localparam int N = W / 4;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_nib
      logic [3:0] nib;
      assign nib = value_i[4*g +: 4];
      assign chars_o[8*g +: 8] = (nib < 4'ha)
        ? drive_report_pkg::ASCII_ZERO + 8'(nib)
        : drive_report_pkg::CH_UPPER_A + 8'(nib) - 8'h0a;
    end
  endgenerate

  // Leading zeros are dropped, but a zero word still sends one digit.
  always_comb
  begin
    count_o = 3'h1;
    for (int i = 0; i < N; i++)
    begin
      if (value_i[4*i +: 4] != 4'h0)
        count_o = 3'(i + 1);
    end
  end

endmodule : hex_text

// ===== logic/decimal_text.sv
module decimal_text #(
  parameter int W = drive_report_pkg::WORD_W,
  parameter int D = drive_report_pkg::DEC_DIGITS
) (
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  input  wire logic               start_i,
  input  wire logic [W-1:0]       value_i,
  output logic                    done_o,
  output logic      [8*D-1:0]     chars_o,
  output logic      [2:0]         count_o
);

  logic [4*D+W-1:0] work;
  logic [4*D+W-1:0] next_work;
  logic [4:0]       steps;
  logic             busy;

  // Shift-and-add-three: one input bit per cycle keeps the logic small.
  always_comb
  begin
    next_work = work;
    for (int d = 0; d < D; d++)
    begin
      if (next_work[W+4*d +: 4] > 4'h4)
        next_work[W+4*d +: 4] = next_work[W+4*d +: 4] + 4'h3;
    end
    next_work = next_work << 1;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      work   <= '0;
      steps  <= 5'h00;
      busy   <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        work  <= {{(4*D){1'b0}}, value_i};
        steps <= 5'h00;
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        work  <= next_work;
        steps <= steps + 5'h01;
        if (steps == 5'(W - 1))
        begin
          busy   <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < D; g++)
    begin : g_dig
      assign chars_o[8*g +: 8] =
        drive_report_pkg::ASCII_ZERO + 8'(work[W+4*g +: 4]);
    end
  endgenerate

  always_comb
  begin
    count_o = 3'h1;
    for (int i = 0; i < D; i++)
    begin
      if (work[W+4*i +: 4] != 4'h0)
        count_o = 3'(i + 1);
    end
  end

endmodule : decimal_text

// ===== testbench/host_command_model.sv
module host_command_model (
  input  wire logic       clock_i,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            tx_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    rx_byte_o  = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  task automatic put(input logic [7:0] c, output bit ok);
    int n;
    n = 0;
    rx_byte_o  <= c;
    rx_valid_o <= 1'b1;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (rx_ready_i !== 1'b1 && n < 40);
    ok = (rx_ready_i === 1'b1);
  endtask : put

  // A query is sent without first looking at the drive's state.
  task automatic query(input string cmd, input bit slow, input int bound,
                       output string reply, output bit ok);
    bit         taken;
    bit         done;
    logic [7:0] last;
    string      s;
    taken = 1'b1;
    done  = 1'b0;
    reply = "";
    s     = " ";
    for (int i = 0; i <= cmd.len(); i++)
    begin
      last = (i == cmd.len()) ? drive_report_pkg::ASCII_CR : cmd[i];
      if (taken)
        put(last, taken);
    end
    rx_valid_o <= 1'b0;
    // The released line shows the inverse so no stale byte looks valid.
    rx_byte_o  <= ~last;
    for (int n = 0; n < bound && !done; n++)
    begin
      tx_ready_o <= slow ? n[0] : 1'b1;
      @(posedge clock_i);
      if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
      begin
        done = (tx_byte_i === drive_report_pkg::ASCII_CR);
        s.putc(0, tx_byte_i);
        if (!done)
          reply = {reply, s};
      end
    end
    tx_ready_o <= 1'b0;
    ok = taken && done;
  endtask : query
endmodule : host_command_model

// ===== testbench/drive_alarm_status_reporter_tb.sv
module drive_alarm_status_reporter_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_byte;
  logic        tx_valid;
  logic        tx_ready;
  logic [15:0] alarm_set = 16'h0000;
  logic        alarm_clear = 1'b0;
  logic        motor_req = 1'b0;
  logic [12:0] live = 13'h0000;
  logic [15:0] alarm_word;
  logic [15:0] cond_word;
  logic        motor_disable;
  logic        fault_branch;
  int          err_count = 0;
  int          tests_run = 0;
  string       fault_hex;
  string       drive_hex;
  string       alarm_dec;
  string       cond_dec;
  int          pos [13] = '{1, 3, 4, 5, 6, 7, 8, 10, 11, 12, 13, 14, 15};

  always #25 clock = ~clock;

  drive_alarm_status_reporter i_drive_alarm_status_reporter (
    .clock_i(clock), .sys_rst_i(sys_rst),
    .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .alarm_set_i(alarm_set), .alarm_clear_i(alarm_clear),
    .motor_enable_req_i(motor_req), .tuner_sampling_i(live[0]),
    .in_position_i(live[1]), .moving_i(live[2]), .jogging_i(live[3]),
    .stopping_i(live[4]), .wait_on_input_op_i(live[5]),
    .saving_i(live[6]), .homing_op_i(live[7]),
    .timed_delay_op_i(live[8]), .wizard_running_i(live[9]),
    .encoder_check_i(live[10]), .program_running_i(live[11]),
    .initializing_i(live[12]), .alarm_word_o(alarm_word),
    .drive_condition_word_o(cond_word), .motor_disable_o(motor_disable),
    .fault_branch_op_o(fault_branch));

  host_command_model i_host_command_model (
    .clock_i(clock), .rx_ready_i(rx_ready), .tx_byte_i(tx_byte),
    .tx_valid_i(tx_valid), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .tx_ready_o(tx_ready));

  ////////////////////////////////////////////////////////////////////////////

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check_word(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_text(string what, string exp, string got);
    tests_run++;
    if (exp != got)
    begin
      err_count++;
      $display("unexpected %s: expected %s, seen %s", what, exp, got);
    end
  endtask : check_text

  // A reply that never completes ends the run at once.
  task automatic ask(string cmd, string val, bit slow);
    string got;
    bit    ok;
    i_host_command_model.query(cmd, slow, 80, got, ok);
    check_text(cmd, {cmd, "=", val}, got);
    if (!ok)
    begin
      err_count++;
      print_verdict();
    end
  endtask : ask

  task automatic raise(logic [15:0] bits, logic clr);
    alarm_set   <= bits;
    alarm_clear <= clr;
    @(posedge clock);
    alarm_set   <= 16'h0000;
    alarm_clear <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : raise

  ////////////////////////////////////////////////////////////////////////////

  task automatic scen_alarm_codes();
    raise(16'h0244, 1'b0);
    check_word("alarm word", 16'h0244, alarm_word);
    ask(fault_hex, "244", 1'b0);
    ask(alarm_dec, "580", 1'b1);
    check_word("held alarm", 16'h0244, alarm_word);
    raise(16'h4cab, 1'b0);
    check_word("combined alarm", 16'h4eef, alarm_word);
    check_word("disable", 16'h0001, {15'h0000, motor_disable});
    check_word("branch", 16'h0001, {15'h0000, fault_branch});
    raise(16'h0001, 1'b1);
    check_word("clear with set", 16'h0001, alarm_word);
    check_word("no disable", 16'h0000, {15'h0000, motor_disable});
    raise(16'hffff, 1'b0);
    ask(fault_hex, "FFFF", 1'b1);
    ask(alarm_dec, "65535", 1'b0);
    raise(16'h0000, 1'b1);
    ask(fault_hex, "0", 1'b0);
    ask(alarm_dec, "0", 1'b1);
  endtask : scen_alarm_codes

  task automatic scen_condition_bits();
    for (int k = 0; k < 13; k++)
    begin
      live <= 13'h0001 << k;
      repeat (3) @(posedge clock);
      check_word("condition bit", 16'h0001 << pos[k], cond_word);
    end
    live      <= 13'h0000;
    motor_req <= 1'b1;
    raise(16'h0004, 1'b0);
    check_word("enabled alarm", 16'h0201, cond_word);
    raise(16'h0008, 1'b0);
    check_word("faulted", 16'h0204, cond_word);
    raise(16'h0000, 1'b1);
    check_word("recovered", 16'h0001, cond_word);
    motor_req <= 1'b0;
  endtask : scen_condition_bits

  task automatic scen_status_reply();
    string got;
    bit    ok;
    live <= 13'h0822;
    repeat (3) @(posedge clock);
    ask(drive_hex, "4088", 1'b0);
    ask(cond_dec, "16520", 1'b1);
    live <= 13'h1004;
    i_host_command_model.query("XY", 1'b0, 40, got, ok);
    check_word("unknown reply", 16'h0000, {15'h0000, ok});
    ask(drive_hex, "8010", 1'b0);
    live <= 13'h0000;
  endtask : scen_status_reply

  initial
  begin
    fault_hex = "  ";
    fault_hex.putc(0, drive_report_pkg::CH_UPPER_A);
    fault_hex.putc(1, drive_report_pkg::CH_UPPER_L);
    drive_hex = "  ";
    drive_hex.putc(0, drive_report_pkg::CH_UPPER_S);
    drive_hex.putc(1, drive_report_pkg::CH_UPPER_C);
    alarm_dec = "   ";
    alarm_dec.putc(0, drive_report_pkg::CH_UPPER_R);
    alarm_dec.putc(1, drive_report_pkg::CH_UPPER_L);
    alarm_dec.putc(2, drive_report_pkg::CH_LOWER_F);
    cond_dec = alarm_dec;
    cond_dec.putc(2, drive_report_pkg::CH_LOWER_S);
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check_word("reset alarm", 16'h0000, alarm_word);
    check_word("reset condition", 16'h0000, cond_word);
    scen_alarm_codes();
    scen_condition_bits();
    scen_status_reply();
    print_verdict();
  end
endmodule : drive_alarm_status_reporter_tb
